// ### wake_sleep_power_control_tb.sv
// Self-checking bench for the wake/sleep power controller.
// Assumes the design package and host model are compiled first.
`timescale 1ns/1ps
module wake_sleep_power_control_tb;
  import wspc_pkg::*;
  logic clk = 0, srst = 1, want = 1, wpol = 0, hpol = 1, usb = 0, slp = 0, attn = 0;
  logic sess = 0, lowp = 0, tx = 0, rx = 0, xrst_n = 1, hidle = 1;
  logic pin, hwake, creq, crst, cen, txe, rxe, rdis, asl, hasl, ron;
  int mismatches = 0, check_count = 0;
  wspc_host_model host (.clk_i(clk), .want_wake_i(want), .pol_high_i(wpol), .host_pol_high_i(hpol),
    .idle_i(hidle), .host_wake_i(hwake), .clk_req_i(creq), .wake_pin_o(pin), .host_asleep_o(hasl),
    .ref_on_o(ron));
  wspc_top #(.POR_CYC(10), .LPO_DIV(4)) uut (.clk_i(clk), .srst_i(srst), .device_wake_request_in_i(pin),
    .ext_rst_n_i(xrst_n), .host_wake_request_out_o(hwake), .ref_clock_request_out_o(creq),
    .wake_pol_high_i(wpol), .host_pol_high_i(hpol), .usb_mode_i(usb), .sleep_enable_i(slp),
    .host_attn_i(attn), .session_active_i(sess), .lowpwr_mode_i(lowp), .session_ticks_i(16'h0008),
    .lowpwr_ticks_i(16'h0006), .pkt_tx_i(tx), .pkt_rx_i(rx), .core_rst_o(crst), .core_clk_en_o(cen),
    .radio_tx_en_o(txe), .radio_rx_en_o(rxe), .radio_disable_o(rdis), .asleep_o(asl));
  initial forever #50 clk = ~clk;
  task chk(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  // Bounded wait for the sleep flag to reach a level.
  task wait_asl(input logic v, input int n);
    int i;
    for (i = 0; i < n && asl !== v; i++) cyc(1);
    chk("asleep_wait", v, asl);
  endtask
  task wait_rst_done;
    int i;
    for (i = 0; i < 60 && crst !== 1'b0; i++) cyc(1);
    chk("core_rst_o", 1'b0, crst);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #400000;
    mismatches++;
    test_done;
  end
  initial begin
    int k;
    logic a, p;
    void'($urandom(32'h360C));
    cyc(5);
    chk("clk_req_rst", 1'b1, creq);
    chk("asleep_rst", 1'b0, asl);
    chk("host_wake_rst", 1'b0, hwake);
    srst = 0;
    wait_rst_done;
    slp = 1;
    cyc(40);
    chk("asleep_held", 1'b0, asl);
    chk("clk_req_awake", 1'b1, creq);
    want = 0;
    wait_asl(1'b1, 10);
    chk("clk_req_sleep", 1'b0, creq);
    chk("clk_en_sleep", 1'b0, cen);
    chk("ref_off", 1'b0, ron);
    tx = 1;
    rx = 1;
    cyc(2);
    chk("tx_en_sleep", 1'b0, txe);
    chk("rx_en_sleep", 1'b0, rxe);
    tx = 0;
    rx = 0;
    wpol = 1;
    want = 1;
    wait_asl(1'b0, 10);
    slp = 0;
    for (k = 0; k < 8; k++) begin
      a = $urandom % 2;
      p = $urandom % 2;
      attn = a;
      hpol = p;
      tx = $urandom % 2;
      rx = $urandom % 2;
      cyc(1);
      chk("radio_tx_en", tx, txe);
      chk("radio_rx_en", rx, rxe);
      cyc(1);
      chk("host_wake", a ~^ p, hwake);
      chk("host_sleep", 1'b0, hasl && a);
    end
    attn = 0;
    tx = 0;
    rx = 0;
    usb = 1;
    cyc(5);
    chk("radio_disable_on", 1'b1, rdis);
    want = 0;
    cyc(5);
    chk("radio_disable_off", 1'b0, rdis);
    usb = 0;
    sess = 1;
    slp = 1;
    wait_asl(1'b1, 10);
    wait_asl(1'b0, 60);
    wait_asl(1'b1, 40);
    want = 1;
    cyc(5);
    for (k = 0; k < 100; k++) begin
      chk("session_awake", 1'b0, asl);
      cyc(1);
    end
    sess = 0;
    lowp = 1;
    want = 0;
    wait_asl(1'b1, 10);
    wait_asl(1'b0, 40);
    xrst_n = 0;
    cyc(5);
    chk("ext_rst_core", 1'b1, crst);
    chk("ext_rst_asleep", 1'b0, asl);
    chk("ext_rst_clk_req", 1'b1, creq);
    xrst_n = 1;
    wait_rst_done;
    test_done;
  end
endmodule

// ### wspc_host_model.sv
// Behavioural host processor and reference clock source facing the power controller.
// Assumes the bench sets the host's wishes; only the host asleep flag is registered on clk_i, the other outputs follow their inputs directly.
`timescale 1ns/1ps
module wspc_host_model (
  // Clock
  input wire logic clk_i,
  // Host wishes and configuration
  input wire logic want_wake_i,
  input wire logic pol_high_i,
  input wire logic host_pol_high_i,
  input wire logic idle_i,
  // Device pins
  input wire logic host_wake_i,
  input wire logic clk_req_i,
  output logic wake_pin_o,
  output logic host_asleep_o,
  output logic ref_on_o
);
  logic attn;
  initial host_asleep_o = 1'b0;
  assign wake_pin_o = want_wake_i ? pol_high_i : ~pol_high_i;
  assign attn = host_wake_i ~^ host_pol_high_i;
  // The source is powered down as soon as nobody asks for it.
  assign ref_on_o = clk_req_i;
  always @(posedge clk_i) host_asleep_o <= idle_i && !attn;
endmodule

// ### wspc_params.svh
// Constants for the wake/sleep power controller.
// Assumes inclusion by bare name from the package and modules.
`ifndef WSPC_PARAMS_SVH
`define WSPC_PARAMS_SVH
`define WSPC_CLK_HZ 10000000
`define WSPC_POR_NS 1000
`define WSPC_POR_CYC ((`WSPC_POR_NS * (`WSPC_CLK_HZ / 1000000) + 999) / 1000)
`define WSPC_LPO_DIV 305
`define WSPC_SNIFF_TICKS 16'h0040
`define WSPC_EVENT_TICKS 16'h0004
`define WSPC_WAKE_POL_RST 1'b0
`define WSPC_HOST_POL_RST 1'b1
`define WSPC_SYNC_STAGES 2
`endif

// ### wspc_pkg.sv
// Types shared by the wake/sleep power controller modules.
// Assumes the params header is on the include path.
`include "wspc_params.svh"
package wspc_pkg;
  typedef enum logic [3:0] {
    WSPC_AWAKE = 4'h1,
    WSPC_SLEEP = 4'h2,
    WSPC_EVENT = 4'h4,
    WSPC_LOWPWR = 4'h8
  } wspc_state_t;
endpackage

// ### wspc_sync.sv
// Two-flop synchroniser for the host wake and external reset pins.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`include "wspc_params.svh"
module wspc_sync #(
  parameter int STAGES = `WSPC_SYNC_STAGES
) (
  input wire logic clk_i,
  input wire logic srst_i,
  wspc_sync_if.snk sif
);
  logic [STAGES-1:0] wake_q;
  logic [STAGES-1:0] rst_q;
  logic [STAGES-1:0] next_wake_q;
  logic [STAGES-1:0] next_rst_q;

  // Elaboration-time check: one stage would let a metastable level reach the decision logic.
  if (STAGES < 2) begin
    $error("wspc_sync needs at least two stages");
  end

  always_comb begin
    next_wake_q = {wake_q[STAGES-2:0], sif.wake_raw};
    next_rst_q = {rst_q[STAGES-2:0], sif.rst_n_raw};
  end

  // Reset idles at inactive levels: wake high (default polarity) and reset released.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wake_q <= {STAGES{1'b1}};
      rst_q <= {STAGES{1'b1}};
    end else begin
      wake_q <= next_wake_q; // R16
      rst_q <= next_rst_q; // R16
    end
  end

  assign sif.wake_sync = wake_q[STAGES-1];
  assign sif.rst_n_sync = rst_q[STAGES-1];
endmodule

// ### wspc_sync_if.sv
// Interface carrying raw and synchronised host-side levels.
// Assumes a single clock domain.
`timescale 1ns/1ps
interface wspc_sync_if;
  logic wake_raw;
  logic rst_n_raw;
  logic wake_sync;
  logic rst_n_sync;
  modport src (output wake_raw, output rst_n_raw, input wake_sync, input rst_n_sync);
  modport snk (input wake_raw, input rst_n_raw, output wake_sync, output rst_n_sync);
endinterface

// ### wspc_top.sv
// Wake/sleep power controller: host wake handshake, clock request, reset and duty cycling.
// Assumes one 10 MHz clock; host pins are asynchronous and synchronised here.
// Behaviour
// R1: While the host wake input is active the device stays fully awake.
// R2: With host wake inactive the device sleeps only once its own sleep criteria hold.
// R3: Host wake polarity is software selectable and defaults to active low.
// R4: The device asserts its host wake output while it needs host attention.
// R5: The host sleeps only when host wake output is inactive and its own criteria hold.
// R6: Host wake output polarity is software selectable.
// R7: Clock request is asserted whenever the reference clock is needed.
// R8: A low external reset holds the block in its power-on state.
// R9: An internal power-on reset initialises the block with no host action.
// R10: Radio transmit and receive enables follow packet activity only; the code also holds both enables off while asleep.
// R11: In sniff, hold and park the block runs from slow ticks and wakes after a preset interval.
// R12: With the USB host link the wake input instead disables the radio.
// R13: A sleeping scan or sniff session is woken by slow-tick timers per event and sleeps after it.
// R14: Host wake during a session keeps the session but blocks sleep between events.
// R15: While asleep core state is kept and nonessential clocks are gated off.
// R16: Wake and reset inputs pass two flip-flop stages before use.
`timescale 1ns/1ps
`include "wspc_params.svh"
module wspc_top
  import wspc_pkg::*;
#(
  parameter int POR_CYC = `WSPC_POR_CYC,
  parameter int LPO_DIV = `WSPC_LPO_DIV
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Host pins
  input wire logic device_wake_request_in_i,
  input wire logic ext_rst_n_i,
  output logic host_wake_request_out_o,
  output logic ref_clock_request_out_o,
  // Software configuration
  input wire logic wake_pol_high_i,
  input wire logic host_pol_high_i,
  input wire logic usb_mode_i,
  input wire logic sleep_enable_i,
  input wire logic host_attn_i,
  input wire logic session_active_i,
  input wire logic lowpwr_mode_i,
  input wire logic [15:0] session_ticks_i,
  input wire logic [15:0] lowpwr_ticks_i,
  // Baseband packet activity
  input wire logic pkt_tx_i,
  input wire logic pkt_rx_i,
  // Outputs to the rest of the chip
  output logic core_rst_o,
  output logic core_clk_en_o,
  output logic radio_tx_en_o,
  output logic radio_rx_en_o,
  output logic radio_disable_o,
  output logic asleep_o
);
  // Elaboration-time checks: both counters are 16 bits wide.
  if (POR_CYC < 1 || POR_CYC > 65535) begin
    $error("POR_CYC must lie between 1 and 65535");
  end
  if (LPO_DIV < 2 || LPO_DIV > 65536) begin
    $error("LPO_DIV must lie between 2 and 65536");
  end

  wspc_sync_if sif ();
  assign sif.wake_raw = device_wake_request_in_i;
  assign sif.rst_n_raw = ext_rst_n_i;
  wspc_sync #(.STAGES(`WSPC_SYNC_STAGES)) u_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .sif(sif)
  );

  // Power-on reset counter; the chip reset also follows the external pin.
  logic [15:0] por_cnt, next_por_cnt;
  logic rst_hold, next_rst_hold;
  logic ext_rst;
  assign ext_rst = !sif.rst_n_sync;
  always_comb begin
    next_por_cnt = por_cnt;
    next_rst_hold = 1'b0;
    if (ext_rst) begin
      next_por_cnt = 16'h0000; // R8
      next_rst_hold = 1'b1; // R8
    end else if (por_cnt < 16'(POR_CYC)) begin
      next_por_cnt = por_cnt + 16'h0001; // R9
      next_rst_hold = 1'b1; // R9
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      por_cnt <= 16'h0000;
      rst_hold <= 1'b1;
    end else begin
      por_cnt <= next_por_cnt;
      rst_hold <= next_rst_hold;
    end
  end

  // Slow oscillator tick, derived as an enable pulse from the system clock.
  logic [15:0] lpo_cnt, next_lpo_cnt;
  logic lpo_tick;
  always_comb begin
    lpo_tick = (lpo_cnt == 16'(LPO_DIV - 1));
    next_lpo_cnt = lpo_tick ? 16'h0000 : lpo_cnt + 16'h0001;
  end
  always_ff @(posedge clk_i) begin
    if (srst_i || rst_hold) lpo_cnt <= 16'h0000;
    else lpo_cnt <= next_lpo_cnt;
  end

  // Wake demand with polarity; in USB mode the pin becomes radio disable instead.
  logic wake_active, host_demand;
  assign wake_active = (sif.wake_sync == wake_pol_high_i); // R3
  assign host_demand = wake_active && !usb_mode_i; // R12

  wspc_state_t state, next_state;
  logic [15:0] tmr, next_tmr;
  logic next_asleep, next_clk_en, next_clk_req, next_tx, next_rx, next_dis, next_host;

  always_comb begin
    next_state = state;
    next_tmr = tmr;
    unique case (state)
      WSPC_AWAKE: begin
        // Sleep only when the host releases wake and the device's own criteria allow.
        if (!host_demand && sleep_enable_i && !host_attn_i) begin // R1 R2 R14
          if (lowpwr_mode_i) begin
            next_state = WSPC_LOWPWR; // R11
            next_tmr = lowpwr_ticks_i;
          end else begin
            next_state = WSPC_SLEEP;
            next_tmr = session_ticks_i;
          end
        end
      end
      WSPC_SLEEP: begin
        if (host_demand || host_attn_i) begin
          next_state = WSPC_AWAKE; // R1
        end else if (session_active_i && lpo_tick) begin
          if (tmr == 16'h0000) begin
            next_state = WSPC_EVENT; // R13
            next_tmr = `WSPC_EVENT_TICKS;
          end else begin
            next_tmr = tmr - 16'h0001;
          end
        end
      end
      WSPC_EVENT: begin
        if (lpo_tick) begin
          if (tmr == 16'h0000) begin
            // After the event, sleep again unless the host now demands wake or host attention is requested.
            next_state = (host_demand || host_attn_i) ? WSPC_AWAKE : WSPC_SLEEP; // R13 R14
            next_tmr = session_ticks_i;
          end else begin
            next_tmr = tmr - 16'h0001;
          end
        end
      end
      WSPC_LOWPWR: begin
        if (host_demand || host_attn_i) begin
          next_state = WSPC_AWAKE; // R1
        end else if (lpo_tick) begin
          if (tmr == 16'h0000) next_state = WSPC_AWAKE; // R11
          else next_tmr = tmr - 16'h0001;
        end
      end
      default: next_state = WSPC_AWAKE;
    endcase
    next_asleep = (next_state == WSPC_SLEEP) || (next_state == WSPC_LOWPWR);
    next_clk_en = !next_asleep; // R15
    next_clk_req = !next_asleep; // R7
    next_tx = !next_asleep && pkt_tx_i; // R10
    next_rx = !next_asleep && pkt_rx_i; // R10
    next_dis = usb_mode_i && wake_active; // R12
    next_host = host_attn_i ~^ host_pol_high_i; // R4 R6
  end

  always_ff @(posedge clk_i) begin
    if (srst_i || rst_hold) begin
      state <= WSPC_AWAKE;
      tmr <= 16'h0000;
      asleep_o <= 1'b0;
      core_clk_en_o <= 1'b1;
      ref_clock_request_out_o <= 1'b1;
      radio_tx_en_o <= 1'b0;
      radio_rx_en_o <= 1'b0;
      radio_disable_o <= 1'b0;
      host_wake_request_out_o <= !`WSPC_HOST_POL_RST;
    end else begin
      state <= next_state;
      tmr <= next_tmr;
      asleep_o <= next_asleep;
      core_clk_en_o <= next_clk_en;
      ref_clock_request_out_o <= next_clk_req;
      radio_tx_en_o <= next_tx;
      radio_rx_en_o <= next_rx;
      radio_disable_o <= next_dis;
      host_wake_request_out_o <= next_host;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) core_rst_o <= 1'b1;
    else core_rst_o <= rst_hold; // R8 R9
  end

  // Assertions.
  wake_blocks_sleep_a: assert property (@(posedge clk_i) disable iff (srst_i || rst_hold) // R1
    host_demand |=> !(state inside {WSPC_SLEEP, WSPC_LOWPWR}))
    else $error("slept while host demanded wake");
  sleep_needs_crit_a: assert property (@(posedge clk_i) disable iff (srst_i || rst_hold) // R2
    (state == WSPC_AWAKE) && !sleep_enable_i |=> state == WSPC_AWAKE)
    else $error("slept without sleep enable");
  wake_polarity_a: assert property (@(posedge clk_i) disable iff (srst_i || rst_hold) // R3
    host_demand == (!usb_mode_i && ($past(device_wake_request_in_i, 2) == wake_pol_high_i)))
    else $error("wake polarity wrong");
  host_wake_out_a: assert property (@(posedge clk_i) disable iff (srst_i || rst_hold) // R4
    host_attn_i |=> host_wake_request_out_o == $past(host_pol_high_i))
    else $error("host wake output not asserted");
  clock_req_a: assert property (@(posedge clk_i) disable iff (srst_i || rst_hold) // R7
    ref_clock_request_out_o == !asleep_o)
    else $error("clock request mismatch");
  ext_reset_a: assert property (@(posedge clk_i) disable iff (srst_i) // R8
    ext_rst |=> ##1 core_rst_o)
    else $error("external reset not applied");
  radio_gate_a: assert property (@(posedge clk_i) disable iff (srst_i || rst_hold) // R10
    asleep_o |-> !radio_tx_en_o && !radio_rx_en_o)
    else $error("radio on while asleep");
  usb_disable_a: assert property (@(posedge clk_i) disable iff (srst_i || rst_hold) // R12
    usb_mode_i && wake_active |=> radio_disable_o)
    else $error("radio disable missed");
  event_resleep_a: assert property (@(posedge clk_i) disable iff (srst_i || rst_hold) // R13
    (state == WSPC_EVENT) && lpo_tick && tmr == 16'h0000 && !host_demand && !host_attn_i
    |=> state == WSPC_SLEEP)
    else $error("no return to sleep after event");
  clk_gate_a: assert property (@(posedge clk_i) disable iff (srst_i || rst_hold) // R15
    core_clk_en_o == !asleep_o)
    else $error("clock gate mismatch");
  cov_sleep_c: cover property (@(posedge clk_i) state == WSPC_SLEEP);
  cov_event_c: cover property (@(posedge clk_i) state == WSPC_EVENT);
  cov_lowpwr_wake_c: cover property (@(posedge clk_i) state == WSPC_LOWPWR ##1 state == WSPC_AWAKE);
endmodule
